// ===== core/sleep_consts.svh
// Constants for the sleep-mode controller: register offsets, fields and timing counts.
`ifndef SLEEP_CONSTS_SVH
`define SLEEP_CONSTS_SVH
`define SLP_CTRL_OFFSET 8'h00
`define SLP_STATUS_OFFSET 8'h04
`define SLP_WAKE_EN_OFFSET 8'h08
`define SLP_ARM_BIT 0
`define SLP_MODE_LSB 1
`define SLP_MODE_MSB 3
`define SLP_BOD_OFF_BIT 4
`define SLP_CTRL_RESET 32'h0000_0000
`define SLP_WAKE_EN_RESET 8'hFF
`define SLP_WAKE_STALL_CYCLES 3'h4
`define SLP_OSC_STARTUP_NS 1000
`define SLP_CLK_PERIOD_NS 10
`define SLP_OSC_STARTUP_CYCLES ((`SLP_OSC_STARTUP_NS + `SLP_CLK_PERIOD_NS - 1) / `SLP_CLK_PERIOD_NS)
`endif

// ===== core/sleep_pkg.sv
// Types shared by the sleep-mode controller files.
package sleep_pkg;
    // Sleep mode select encodings.
    typedef enum logic [2:0] {
        MODE_IDLE = 3'h0,
        MODE_ADC_NR = 3'h1,
        MODE_PWR_DOWN = 3'h2,
        MODE_PWR_SAVE = 3'h3,
        MODE_RSVD4 = 3'h4,
        MODE_RSVD5 = 3'h5,
        MODE_STANDBY = 3'h6,
        MODE_EXT_STANDBY = 3'h7
    } sleep_mode_e;
    // Wake source bit positions in an eight-bit source vector.
    typedef enum logic [2:0] {
        SRC_EXT_LEVEL = 3'h0,
        SRC_EXT_EDGE = 3'h1,
        SRC_ADDR_MATCH = 3'h2,
        SRC_TIMER_TWO = 3'h3,
        SRC_MEM_READY = 3'h4,
        SRC_CONV_DONE = 3'h5,
        SRC_WATCHDOG = 3'h6,
        SRC_SERIAL = 3'h7
    } wake_src_e;
    // Controller sequence states, one-hot.
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_SLEEP = 4'h2,
        ST_STARTUP = 4'h4,
        ST_STALL = 4'h8
    } seq_state_e;
endpackage

// ===== core/wake_source_filter.sv
// Per-mode wake source gating and clock domain enable table.
`timescale 1ns/1ps
module wake_source_filter (
    input wire logic [2:0] mode,
    input wire logic timer_async,
    input wire logic [7:0] src_pending,
    input wire logic [7:0] src_enable,
    input wire logic other_io_event,
    output logic wake_hit,
    output logic [4:0] domain_run,
    output logic main_osc_run,
    output logic timer_osc_run,
    output logic bod_off_allowed
);
    logic [7:0] valid_mask;
    logic [7:0] hits;
    logic other_ok;

    // Builds the valid wake sources and running clocks for the mode.
    always_comb begin
        valid_mask = 8'h00;
        domain_run = 5'h00;
        main_osc_run = 1'b0;
        timer_osc_run = 1'b0;
        bod_off_allowed = 1'b0;
        other_ok = 1'b0;
        unique case (mode)
            3'h0: begin
                valid_mask = 8'hFF;
                domain_run = 5'h1C;
                main_osc_run = 1'b1;
                other_ok = 1'b1;
                timer_osc_run = timer_async;
                valid_mask[sleep_pkg::SRC_TIMER_TWO] = timer_async;
            end
            3'h1: begin
                valid_mask = 8'hFD;
                domain_run = 5'h18;
                main_osc_run = 1'b1;
                timer_osc_run = timer_async;
                valid_mask[sleep_pkg::SRC_TIMER_TWO] = timer_async;
            end
            3'h2, 3'h6: begin
                // deep modes wake on few sources
                valid_mask = 8'hC5;
                bod_off_allowed = 1'b1;
                main_osc_run = (mode == 3'h6);
            end
            3'h3, 3'h7: begin
                valid_mask = 8'hC5;
                valid_mask[sleep_pkg::SRC_TIMER_TWO] = timer_async;
                domain_run = {timer_async, 4'h0};
                timer_osc_run = timer_async;
                main_osc_run = (mode == 3'h7);
                bod_off_allowed = 1'b1;
            end
            default: begin
                valid_mask = 8'h00;
            end
        endcase
    end

    assign hits = src_pending & src_enable & valid_mask;
    assign wake_hit = (|hits) | (other_ok & other_io_event);
endmodule

// ===== core/axil_sleep_regs.sv
// AXI4-Lite register slave for the sleep-mode controller.
`timescale 1ns/1ps
`include "sleep_consts.svh"
module axil_sleep_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] status_word,
    output logic [4:0] ctrl_r,
    output logic [7:0] wake_en_r
);
    logic [7:0] awaddr_r;
    logic aw_held_r;
    logic [7:0] wdata_r;
    logic w_held_r;
    logic do_write;

    // Write address and data are taken independently.
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign do_write = aw_held_r && w_held_r;
    assign s_axi_arready = !s_axi_rvalid;

    // Captures write address and data.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 8'h00;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            end
        end
    end

    // Updates registers and the write response.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= 5'h00;
            wake_en_r <= `SLP_WAKE_EN_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                if (awaddr_r[7:2] == 6'(`SLP_CTRL_OFFSET >> 2)) begin
                    ctrl_r <= wdata_r[4:0];
                end else if (awaddr_r[7:2] == 6'(`SLP_WAKE_EN_OFFSET >> 2)) begin
                    wake_en_r <= wdata_r;
                end else if (awaddr_r[7:2] != 6'(`SLP_STATUS_OFFSET >> 2)) begin
                    s_axi_bresp <= 2'h2;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel with one-cycle answer.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case (s_axi_araddr[7:2])
                6'h00: s_axi_rdata <= {27'h0, ctrl_r};
                6'h01: s_axi_rdata <= status_word;
                6'h02: s_axi_rdata <= {24'h0, wake_en_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ===== core/sleep_mode_controller.sv
// Sleep-mode controller: sleep entry, clock gating and wake-up sequencing.
`timescale 1ns/1ps
`include "sleep_consts.svh"
module sleep_mode_controller (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_instr,
    input wire logic timer_async,
    input wire logic ext_irq_level,
    input wire logic ext_irq_edge,
    input wire logic pin_change_interrupt,
    input wire logic addr_match,
    input wire logic timer_two_irq,
    input wire logic mem_ready,
    input wire logic conv_done,
    input wire logic watchdog_irq,
    input wire logic serial_start_frame,
    input wire logic other_io_event,
    input wire logic brownout_enable,
    output logic core_stall,
    output logic irq_dispatch,
    output logic core_domain_clock_en,
    output logic program_memory_clock_en,
    output logic peripheral_io_clock_en,
    output logic converter_clock_en,
    output logic async_timer_clock_en,
    output logic main_osc_en,
    output logic timer_osc_en,
    output logic brownout_active,
    output logic sleeping
);
    localparam logic [7:0] STARTUP_CYCLES = 8'(`SLP_OSC_STARTUP_CYCLES);

    logic [4:0] ctrl_r;
    logic [7:0] wake_en_r;
    logic [2:0] mode_r;
    logic bod_off_r;
    logic [7:0] pend_meta_r;
    logic [7:0] pend_r;
    logic [1:0] other_sync_r;
    logic [7:0] raw_src;
    logic wake_hit;
    logic [4:0] dom_run;
    logic osc_run;
    logic tosc_run;
    logic bod_off_ok;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    sleep_pkg::seq_state_e state_r;
    sleep_pkg::seq_state_e state_nxt;
    logic [31:0] status_word;
    logic sleep_go;

    // Register slave for control, status and wake enables.
    axil_sleep_regs regs (
        .clk(clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .status_word(status_word),
        .ctrl_r(ctrl_r),
        .wake_en_r(wake_en_r)
    );

    // Source vector; the serial input is start-frame detect only.
    // only start frame reaches wake
    assign raw_src = {serial_start_frame, watchdog_irq, conv_done, mem_ready,
                      timer_two_irq, addr_match, ext_irq_edge,
                      ext_irq_level | pin_change_interrupt};

    // Two-flop synchronisers for the asynchronous wake sources.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pend_meta_r[gi] <= 1'b0;
                    pend_r[gi] <= 1'b0;
                end else begin
                    pend_meta_r[gi] <= raw_src[gi];
                    pend_r[gi] <= pend_meta_r[gi];
                end
            end
        end
    endgenerate

    // Synchroniser for the generic I/O event.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            other_sync_r <= 2'h0;
        end else begin
            other_sync_r <= {other_sync_r[0], other_io_event};
        end
    end

    // Per-mode gating of sources and clock domains.
    wake_source_filter filt (
        .mode(mode_r),
        .timer_async(timer_async),
        .src_pending(pend_r),
        .src_enable(wake_en_r),
        .other_io_event(other_sync_r[1]),
        .wake_hit(wake_hit),
        .domain_run(dom_run),
        .main_osc_run(osc_run),
        .timer_osc_run(tosc_run),
        .bod_off_allowed(bod_off_ok)
    );

    assign sleep_go = sleep_instr && ctrl_r[`SLP_ARM_BIT] && state_r == sleep_pkg::ST_RUN;

    // Sequencer next state.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            sleep_pkg::ST_RUN: begin
                if (sleep_go) begin
                    state_nxt = sleep_pkg::ST_SLEEP;
                end
            end
            sleep_pkg::ST_SLEEP: begin
                if (wake_hit) begin
                    state_nxt = sleep_pkg::ST_STARTUP;
                    cnt_nxt = osc_run ? 8'h01 : STARTUP_CYCLES;
                end
            end
            sleep_pkg::ST_STARTUP: begin
                if (cnt_r <= 8'h01) begin
                    state_nxt = sleep_pkg::ST_STALL;
                    cnt_nxt = {5'h00, `SLP_WAKE_STALL_CYCLES};
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            sleep_pkg::ST_STALL: begin
                if (cnt_r <= 8'h01) begin
                    state_nxt = sleep_pkg::ST_RUN;
                    cnt_nxt = 8'h00;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
        endcase
    end

    // reset in sleep returns to run
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= sleep_pkg::ST_RUN;
            cnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= 3'h0;
            bod_off_r <= 1'b0;
        end else if (sleep_go) begin
            mode_r <= ctrl_r[`SLP_MODE_MSB:`SLP_MODE_LSB];
            bod_off_r <= ctrl_r[`SLP_BOD_OFF_BIT];
        end
    end

    // One-cycle pulse to run the interrupt handler.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_dispatch <= 1'b0;
        end else begin
            irq_dispatch <= state_r == sleep_pkg::ST_STALL && state_nxt == sleep_pkg::ST_RUN;
        end
    end

    // Clock enables; clocks only gate, so register and memory hold.
    // state kept by gating only
    always_comb begin
        sleeping = state_r == sleep_pkg::ST_SLEEP;
        core_stall = state_r != sleep_pkg::ST_RUN;
        core_domain_clock_en = !sleeping;
        program_memory_clock_en = !sleeping;
        peripheral_io_clock_en = !sleeping || dom_run[2];
        converter_clock_en = !sleeping || dom_run[3];
        async_timer_clock_en = !sleeping || dom_run[4];
        main_osc_en = !sleeping || osc_run;
        timer_osc_en = timer_async && (!sleeping || tosc_run);
        brownout_active = brownout_enable && !(sleeping && bod_off_r && bod_off_ok);
    end

    // Status word: sleeping flag, latched mode and one-hot state.
    assign status_word = {20'h00000, state_r, 4'h0, mode_r, sleeping};

    // chk_unarmed_no_sleep: sleep instruction without arm does not enter sleep.
    chk_unarmed_no_sleep: assert property (@(posedge clk) disable iff (rst)
        (state_r == sleep_pkg::ST_RUN && sleep_instr && !ctrl_r[0]) |=> !sleeping)
        else $error("unarmed sleep entered sleep");

    chk_armed_enter: assert property (@(posedge clk) disable iff (rst)
        (state_r == sleep_pkg::ST_RUN && sleep_instr && ctrl_r[0]) |=> sleeping)
        else $error("armed sleep not entered");

    chk_stall_four: assert property (@(posedge clk) disable iff (rst)
        $rose(state_r == sleep_pkg::ST_STALL) |-> core_stall [*4] ##1 irq_dispatch)
        else $error("wake stall not four cycles");

    chk_wake_leaves: assert property (@(posedge clk) disable iff (rst)
        (sleeping && wake_hit) |=> state_r == sleep_pkg::ST_STARTUP)
        else $error("wake source ignored");

    chk_idle_clocks: assert property (@(posedge clk) disable iff (rst)
        (sleeping && mode_r == 3'h0) |-> !core_domain_clock_en && peripheral_io_clock_en
        && main_osc_en) else $error("idle clock gating wrong");

    chk_noise_clocks: assert property (@(posedge clk) disable iff (rst)
        (sleeping && mode_r == 3'h1) |-> !peripheral_io_clock_en && converter_clock_en)
        else $error("noise reduction clocks wrong");

    chk_pdown_clocks: assert property (@(posedge clk) disable iff (rst)
        (sleeping && mode_r == 3'h2) |-> !main_osc_en && !async_timer_clock_en)
        else $error("power-down clocks running");

    chk_async_follow: assert property (@(posedge clk) disable iff (rst)
        (sleeping && mode_r == 3'h3) |-> async_timer_clock_en == timer_async)
        else $error("async domain wrong in power-save");

    chk_standby_osc: assert property (@(posedge clk) disable iff (rst)
        (sleeping && mode_r == 3'h6) |-> main_osc_en && !peripheral_io_clock_en)
        else $error("standby oscillator off");

    chk_edge_deep: assert property (@(posedge clk) disable iff (rst)
        (sleeping && mode_r == 3'h2 && pend_r == 8'h02 && !other_sync_r[1]) |=> sleeping)
        else $error("edge interrupt woke deep mode");

    chk_bod_idle: assert property (@(posedge clk) disable iff (rst)
        (sleeping && mode_r == 3'h0 && brownout_enable) |-> brownout_active)
        else $error("brown-out disabled in idle");

    chk_mode_latched: assert property (@(posedge clk) disable iff (rst)
        sleep_go |=> mode_r == $past(ctrl_r[`SLP_MODE_MSB:`SLP_MODE_LSB]))
        else $error("sleep mode not latched");

    chk_stall_no_dispatch: assert property (@(posedge clk) disable iff (rst)
        core_stall |-> !irq_dispatch)
        else $error("handler dispatched during stall");

    chk_deep_startup: assert property (@(posedge clk) disable iff (rst)
        (sleeping && wake_hit && !main_osc_en) |=> (state_r == sleep_pkg::ST_STARTUP) [*8])
        else $error("start-up cut short");

    chk_deep_bod: assert property (@(posedge clk) disable iff (rst)
        (sleeping && mode_r[1] && bod_off_r) |-> !brownout_active)
        else $error("brown-out not disabled in deep mode");

    chk_noise_bod: assert property (@(posedge clk) disable iff (rst)
        (sleeping && mode_r == 3'h1 && brownout_enable) |-> brownout_active)
        else $error("brown-out disabled in noise reduction");

    chk_run_clocks: assert property (@(posedge clk) disable iff (rst)
        !sleeping |-> core_domain_clock_en && program_memory_clock_en && main_osc_en)
        else $error("clock stopped outside sleep");

    chk_timer_osc: assert property (@(posedge clk) disable iff (rst)
        (sleeping && !timer_async) |-> !timer_osc_en)
        else $error("timer oscillator on without async mode");

    chk_deep_domains: assert property (@(posedge clk) disable iff (rst)
        (sleeping && mode_r[1]) |-> !core_domain_clock_en && !peripheral_io_clock_en
        && !converter_clock_en) else $error("domain clock running in deep mode");
endmodule

// ===== tb/sleep_mode_controller_tb.sv
// Self-checking testbench for the sleep-mode controller.
`timescale 1ns/1ps
`include "sleep_consts.svh"
module sleep_mode_controller_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic sleep_instr, timer_async, brownout_enable, core_stall, irq_dispatch;
    logic brownout_active, sleeping;
    logic [9:0] src;
    wire [6:0] en;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    logic [6:0] en_tab [6] = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02, 7'h07};
    logic [2:0] mode_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

    sleep_mode_controller DUT (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_instr, .timer_async,
        .ext_irq_level(src[0]), .ext_irq_edge(src[1]), .pin_change_interrupt(src[2]),
        .addr_match(src[3]), .timer_two_irq(src[4]), .mem_ready(src[5]),
        .conv_done(src[6]), .watchdog_irq(src[7]), .serial_start_frame(src[8]),
        .other_io_event(src[9]), .brownout_enable, .core_stall, .irq_dispatch,
        .core_domain_clock_en(en[6]), .program_memory_clock_en(en[5]),
        .peripheral_io_clock_en(en[4]), .converter_clock_en(en[3]),
        .async_timer_clock_en(en[2]), .main_osc_en(en[1]), .timer_osc_en(en[0]),
        .brownout_active, .sleeping
    );

    // The clock toggles every half period.
    always #5 clk = ~clk;

    // A hung run is cut short and counted as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    // Compares a result and counts the mismatch.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Writes one register; address and data are released as each is taken.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_p;
        logic w_p;
        logic got;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge clk);
            if (aw_p && s_axi_awready) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (!aw_p && !w_p && s_axi_bvalid) begin
                got = 1'b1;
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask

    // Reads one register into rd and its response into rs.
    task automatic axi_read(input logic [7:0] a);
        logic ar_p;
        logic got;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ar_p = 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge clk);
            if (ar_p && s_axi_arready) begin
                ar_p = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (!ar_p && s_axi_rvalid) begin
                got = 1'b1;
                rd = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
    endtask

    // Arms the chosen mode with brown-out disable requested, then sleeps.
    task automatic enter(input logic [2:0] m);
        axi_write(`SLP_CTRL_OFFSET, {27'h0, 1'b1, m, 1'b1});
        @(posedge clk);
        sleep_instr <= 1'b1;
        @(posedge clk);
        sleep_instr <= 1'b0;
        @(posedge clk);
        chk("sleeping", 32'h1, sleeping);
    endtask

    // Raises one source and measures the stall and the handler dispatch.
    task automatic wake(input int idx, input logic osc_on);
        logic seen;
        @(posedge clk);
        src[idx] <= 1'b1;
        n = 0;
        seen = 1'b0;
        while (sleeping === 1'b1) @(posedge clk);
        while (core_stall === 1'b1) begin
            n++;
            @(posedge clk);
        end
        repeat (3) begin
            if (irq_dispatch === 1'b1) seen = 1'b1;
            @(posedge clk);
        end
        src <= '0;
        chk("stall_cycles", `SLP_WAKE_STALL_CYCLES + (osc_on ? 1 : `SLP_OSC_STARTUP_CYCLES), n);
        chk("irq_dispatch", 32'h1, seen);
        axi_read(`SLP_STATUS_OFFSET);
        chk("status_run", 32'h100, rd & 32'hF01);
    endtask

    // Raises a source that must be ignored in the current mode.
    task automatic no_wake(input int idx);
        @(posedge clk);
        src[idx] <= 1'b1;
        repeat (8) @(posedge clk);
        src[idx] <= 1'b0;
        chk("still_asleep", 32'h1, sleeping);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("Checks made: %0d, mismatches: %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence of scenarios.
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {sleep_instr, src} = '0;
        timer_async = 1'b1;
        brownout_enable = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        axi_read(`SLP_CTRL_OFFSET);
        chk("ctrl_reset", 32'h0, rd);
        axi_read(`SLP_WAKE_EN_OFFSET);
        chk("wake_en_reset", 32'hFF, rd);
        chk("run_enables", 32'h7F, en);
        axi_read(8'h0C);
        chk("unmapped_resp", 32'h2, rs);
        axi_write(`SLP_CTRL_OFFSET, 32'h0000_0004);
        chk("write_resp", 32'h0, rs);
        @(posedge clk);
        sleep_instr <= 1'b1;
        @(posedge clk);
        sleep_instr <= 1'b0;
        @(posedge clk);
        chk("unarmed_sleep", 32'h0, sleeping);
        for (int i = 0; i < 6; i++) begin
            enter(mode_tab[i]);
            chk("clock_enables", en_tab[i], en);
            chk("brownout_active", (i < 2), brownout_active);
            axi_read(`SLP_STATUS_OFFSET);
            chk("status_sleep", 32'h201 | (mode_tab[i] << 1), rd & 32'hF0F);
            wake(7, en_tab[i][1]);
        end
        // asynchronous timer gating without asynchronous mode.
        @(posedge clk);
        timer_async <= 1'b0;
        enter(3'h3);
        chk("save_sync_en", 32'h0, en);
        no_wake(4);
        wake(8, 1'b0);
        enter(3'h0);
        chk("idle_sync_en", 32'h1E, en);
        no_wake(4);
        wake(9, 1'b1);
        @(posedge clk);
        timer_async <= 1'b1;
        // deep modes ignore edge, converter and other sources.
        enter(3'h2);
        no_wake(1);
        no_wake(6);
        no_wake(9);
        wake(0, 1'b0);
        enter(3'h0);
        wake(1, 1'b1);
        // a masked source does not wake.
        axi_write(`SLP_WAKE_EN_OFFSET, 32'h0000_00BF);
        enter(3'h0);
        no_wake(7);
        axi_write(`SLP_WAKE_EN_OFFSET, 32'h0000_00FF);
        wake(3, 1'b1);
        // reset in sleep restarts instead of resuming.
        enter(3'h2);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("reset_sleeping", 32'h0, sleeping);
        chk("reset_stall", 32'h0, core_stall);
        chk("reset_enables", 32'h7F, en);
        axi_read(`SLP_CTRL_OFFSET);
        chk("reset_ctrl", 32'h0, rd);
        end_of_test();
    end
endmodule
